// ==== socf_top.v ====
// Notes on behaviour
// [R1] The protocol select bit picks SENT when 0 (reset default) and PWM when 1.
// [R2] The zero-field trim is a 12-bit two's-complement value in bits 11:0 of its word.
// [R3] The signed trim is added to the digital field response to shift the zero-field baseline.
// [R4] Until software writes the trim, a factory baseline value is used instead.
// [R5] Two scratch fields of 12 and 24 bits keep whatever software writes to them.
// [R6] The scratch fields feed no processing or output other than the bus read-back on hrdata.
// [R7] A 4-bit coarse gain code in bits 5:2 of its word sets the output-per-field gain.
// [R8] Each gain code maps to a field range from the code-to-range table.
// [R9] Code 0000, the reset default, gives the factory default gain.
// [R10] The programmer should avoid codes 1110 and 1111, which give reduced accuracy.
// [R11] The stored gain code and protocol select steer the signal path and output select from reset onward.
`timescale 1ns/100ps
`default_nettype none
`include "socf_defs.vh"
module socf_top #(
   parameter [11:0] FACTORY_BASELINE = 12'h800, // Arbitrary plain default
   parameter [11:0] DATA_W           = 12'h00c
)(
   input  wire        clk,
   input  wire        resetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   output reg         pwm_select,
   output reg  [11:0] field_out,
   output reg  [11:0] range_gauss_div50
);

   // Configuration state
   reg [3:0]  gain_code_reg;
   reg        proto_reg;
   reg [11:0] trim_reg;
   reg        trim_set_reg;
   reg [11:0] note_short_reg;
   reg [23:0] note_long_reg;
   reg [11:0] field_in_reg;
   // Data-phase capture
   reg        wr_pend_reg;
   reg        rd_pend_reg;
   reg [7:0]  addr_reg;

   wire        take = hsel & hready & htrans[1];
   wire [7:0]  widx = haddr[9:2];
   wire [11:0] eff_trim;
   wire [11:0] gained;
   wire [11:0] sum;

   // Field range per coarse gain code, in units of 50 gauss
   function [11:0] range_of;
      input [3:0] code;
      begin
         case (code)
            4'h0: range_of = 12'h00a; // 500 G, factory default gain
            4'h1: range_of = 12'h003; // 150 G
            4'h2: range_of = 12'h004;
            4'h3: range_of = 12'h005;
            4'h4: range_of = 12'h006;
            4'h5: range_of = 12'h008;
            4'h6: range_of = 12'h00c; // 625 G rounded down
            4'h7: range_of = 12'h00f;
            4'h8: range_of = 12'h011; // 875 G rounded down
            4'h9: range_of = 12'h014;
            4'ha: range_of = 12'h019;
            4'hb: range_of = 12'h01e;
            4'hc: range_of = 12'h023;
            4'hd: range_of = 12'h028;
            4'he: range_of = 12'h002; // 100 G, reduced accuracy
            4'hf: range_of = 12'h02d; // Reduced accuracy
            default: range_of = 12'h00a;
         endcase
      end
   endfunction

   // Gain as left or right shift of the raw field sample, unshifted for codes 0 and 5
   function [11:0] scale;
      input [11:0] raw;
      input [3:0]  code;
      begin
         case (code)
            4'h0: scale = raw;
            4'h1: scale = raw <<< 2;
            4'h2, 4'h3, 4'h4: scale = raw <<< 1;
            4'h5: scale = raw;
            4'h6, 4'h7, 4'h8, 4'h9: scale = {raw[11], raw[11:1]};
            4'he: scale = raw <<< 1;
            default: scale = {{2{raw[11]}}, raw[11:2]};
         endcase
      end
   endfunction

   assign eff_trim = trim_set_reg ? trim_reg : FACTORY_BASELINE; // [R4]
   assign gained   = scale(field_in_reg, gain_code_reg);         // [R7]
   assign sum      = gained + eff_trim;                          // [R2] [R3]

   // Bus address phase capture
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg    <= 8'h00;
      end
      else if (hready)
      begin
         wr_pend_reg <= take & hwrite;
         rd_pend_reg <= take & ~hwrite;
         addr_reg    <= widx;
      end
   end

   // Register writes in data phase
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         gain_code_reg  <= `SOCF_GAIN_RST;  // [R9] [R11]
         proto_reg      <= `SOCF_PROTO_RST; // [R1]
         trim_reg       <= `SOCF_TRIM_RST;
         trim_set_reg   <= 1'b0;
         note_short_reg <= `SOCF_NOTE_S_RST;
         note_long_reg  <= `SOCF_NOTE_L_RST;
         field_in_reg   <= 12'h000;
      end
      else if (wr_pend_reg)
      begin
         case (addr_reg)
            `SOCF_IDX_GAIN:
               gain_code_reg <= hwdata[`SOCF_GAIN_MSB:`SOCF_GAIN_LSB]; // [R7]
            `SOCF_IDX_PROTO:
               proto_reg <= hwdata[`SOCF_PROTO_BIT]; // [R1]
            `SOCF_IDX_TRIM:
            begin
               trim_reg       <= hwdata[`SOCF_TRIM_MSB:0]; // [R2]
               trim_set_reg   <= 1'b1;
               note_short_reg <= hwdata[`SOCF_NOTE_S_MSB:`SOCF_NOTE_S_LSB]; // [R5]
            end
            `SOCF_IDX_NOTE_LONG:
               note_long_reg <= hwdata[`SOCF_NOTE_L_MSB:0]; // [R5]
            `SOCF_IDX_FIELD_IN:
               field_in_reg <= hwdata[11:0];
            default:
               field_in_reg <= field_in_reg;
         endcase
      end
   end

   // Read mux, unmapped reads as zero
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         hrdata <= 32'h0000_0000;
      else if (take & ~hwrite)
      begin
         case (widx)
            `SOCF_IDX_GAIN:      hrdata <= {26'h000_0000, gain_code_reg, 2'b00};
            `SOCF_IDX_PROTO:     hrdata <= {28'h000_0000, proto_reg, 3'b000};
            `SOCF_IDX_TRIM:      hrdata <= {8'h00, note_short_reg, trim_reg};
            `SOCF_IDX_NOTE_LONG: hrdata <= {8'h00, note_long_reg};
            `SOCF_IDX_FIELD_IN:  hrdata <= {20'h0_0000, field_in_reg};
            `SOCF_IDX_RESULT:    hrdata <= {20'h0_0000, field_out};
            `SOCF_IDX_STATUS:    hrdata <= {19'h0_0000, trim_set_reg, range_gauss_div50};
            default:             hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // Outputs: scratch fields feed none of these
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         hreadyout         <= 1'b1;
         hresp             <= 1'b0;
         pwm_select        <= 1'b0;
         field_out         <= 12'h000;
         range_gauss_div50 <= 12'h00a;
      end
      else
      begin
         hreadyout         <= 1'b1;
         hresp             <= 1'b0;
         pwm_select        <= proto_reg;               // [R1] [R6] [R11]
         field_out         <= sum;                     // [R3] [R6]
         range_gauss_div50 <= range_of(gain_code_reg); // [R8]
      end
   end

endmodule // socf_top
`default_nettype wire

// ==== socf_defs.vh ====
`ifndef SOCF_DEFS_VH
`define SOCF_DEFS_VH
// Register indices, byte address is index times four
`define SOCF_IDX_GAIN        8'h08
`define SOCF_IDX_PROTO       8'h1C
`define SOCF_IDX_TRIM        8'h1D
`define SOCF_IDX_NOTE_LONG   8'h1F
`define SOCF_IDX_FIELD_IN    8'h20
`define SOCF_IDX_RESULT      8'h21
`define SOCF_IDX_STATUS      8'h22
// Field positions
`define SOCF_GAIN_LSB        2
`define SOCF_GAIN_MSB        5
`define SOCF_PROTO_BIT       3
`define SOCF_TRIM_MSB        11
`define SOCF_NOTE_S_LSB      12
`define SOCF_NOTE_S_MSB      23
`define SOCF_NOTE_L_MSB      23
// Reset values
`define SOCF_GAIN_RST        4'h0
`define SOCF_PROTO_RST       1'b0
`define SOCF_TRIM_RST        12'h000
`define SOCF_NOTE_S_RST      12'h000
`define SOCF_NOTE_L_RST      24'h00_0000
`endif

// ==== socf_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module socf_sva (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        pwm_select,
   input wire logic [11:0] field_out,
   input wire logic [11:0] range_gauss_div50
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic       dph, rph, gset, pset;
   logic [9:0] ra;
   wire        tk = hsel & hready & htrans[1];
   // Data phase tracking and first-write flags
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
      begin
         {dph, rph, gset, pset, ra} <= '0;
      end
      else
      begin
         dph <= tk & hwrite;
         rph <= tk & !hwrite;
         if (tk) ra <= haddr[9:0];
         if (dph && ra == 10'h020) gset <= 1'b1;
         if (dph && ra == 10'h070) pset <= 1'b1;
      end
   a_ready_high: assert property (hreadyout) else $error("wait state seen");
   a_resp_okay: assert property (!hresp) else $error("error response seen");
   a_proto_default: assert property (!pset |-> !pwm_select) else $error("pwm before write");
   a_proto_follow: assert property (dph && ra == 10'h070 |-> ##2 pwm_select == $past(hwdata[3], 2))
      else $error("protocol select not taken");
   a_range_default: assert property (!gset |-> range_gauss_div50 == 12'h00a) else $error("default range");
   a_note_quiet: assert property (dph && ra == 10'h07c && !$past(dph) |=> $stable(field_out))
      else $error("note write moved output");
   a_result_mirror: assert property (rph && ra == 10'h084 |-> hrdata[11:0] == $past(field_out))
      else $error("result differs from output");
   a_unmapped_zero: assert property (rph && ra == 10'h03c |-> hrdata == 32'h0000_0000) else $error("unmapped read");
   cover property (dph && ra == 10'h074);
   cover property (pwm_select);
   cover property (rph && ra == 10'h088);
endmodule // socf_sva
bind socf_top socf_sva u_sva (.*);
`default_nettype wire

// ==== socf_rx.sv ====
`timescale 1ns/100ps
`default_nettype none
module socf_rx (
   input wire logic        clk,
   input wire logic        pwm_select,
   input wire logic [11:0] field_out,
   output logic [11:0]     sent_word,
   output logic [11:0]     pwm_word
);
   // Capture the word on the selected protocol only
   always @(posedge clk)
      if (pwm_select) pwm_word <= field_out;
      else sent_word <= field_out;
endmodule // socf_rx
`default_nettype wire

// ==== sensor_output_config_fields_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module sensor_output_config_fields_test;
   logic        clk = 0, resetn = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, rd;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, pwm_select;
   wire  [11:0] field_out, range_gauss_div50, sent_word, pwm_word;
   wire         hready = hreadyout;
   int          mismatches = 0, samples_checked = 0;
   logic [11:0] rng [16] = '{10, 3, 4, 5, 6, 8, 12, 15, 17, 20, 25, 30, 35, 40, 2, 45};
   logic [11:0] sc [16] = '{16, 64, 32, 32, 32, 16, 8, 8, 8, 8, 4, 4, 4, 4, 32, 4};
   socf_top dut (.*);
   socf_rx rx (.*);
   initial forever #12.5 clk = ~clk;
   task automatic chk(input logic [31:0] g, e);
      samples_checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // One single AHB transfer, bus driven back to idle in its data phase
   task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
      @(posedge clk);
      {hsel, htrans, hwrite} <= {1'b1, 2'h2, w};
      haddr <= a;
      do @(posedge clk); while (hready !== 1'b1);
      {hsel, htrans} <= 3'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic t_reset;
      bus(0, 10'h020, 0);
      chk(rd, 0);
      bus(0, 10'h070, 0);
      chk(rd, 0);
      chk(field_out, 12'h800);
      chk(range_gauss_div50, 12'h00a);
   endtask
   task automatic t_trim;
      bus(1, 10'h080, 32'h0000_0010);
      settle;
      chk(field_out, 12'h810);
      bus(1, 10'h074, 32'h00ab_cfae);
      settle;
      chk(field_out, 12'hfbe);
      chk(sent_word, 12'hfbe);
      bus(0, 10'h074, 0);
      chk(rd, 32'h00ab_cfae);
      bus(0, 10'h088, 0);
      chk(rd, 32'h0000_100a);
   endtask
   task automatic t_notes;
      bus(1, 10'h07c, 32'h0012_3456);
      bus(1, 10'h03c, 32'hffff_ffff);
      settle;
      chk(field_out, 12'hfbe);
      bus(0, 10'h07c, 0);
      chk(rd, 32'h0012_3456);
      bus(0, 10'h03c, 0);
      chk(rd, 0);
      bus(0, 10'h084, 0);
      chk(rd, 32'h0000_0fbe);
   endtask
   task automatic t_proto;
      bus(1, 10'h070, 32'h0000_0008);
      settle;
      chk(pwm_select, 1);
      chk(pwm_word, 12'hfbe);
      bus(1, 10'h070, 0);
      settle;
      chk(pwm_select, 0);
   endtask
   // Every gain code, reduced-accuracy codes last
   task automatic t_gain;
      for (int c = 0; c < 16; c++)
      begin
         bus(1, 10'h020, c << 2);
         settle;
         chk(range_gauss_div50, rng[c]);
         chk(field_out, sc[c] + 12'hfae);
      end
   endtask
   task automatic complete_run;
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      #50000;
      mismatches++;
      complete_run;
   end
   initial
   begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      t_reset;
      t_trim;
      t_notes;
      t_proto;
      t_gain;
      complete_run;
   end
endmodule // sensor_output_config_fields_test
`default_nettype wire
